// >>> hw/rss_sequencer.sv
// Purpose: Collects reset sources and sequences the core reset
// Assumes: Inputs synchronous to clock; register port never waits
// Notes:   Threshold level and read data leave flip-flops
// Operation
// - Low reset pin fully resets, pc zero
// - Core held inactive while pin low
// - Startup delay after pin release
// - Brownout reset on while running, except in power down
// - Ignore low supply shorter than debounce
// - Four valid threshold codes decoded
// - Invalid code: soft delay reset, restore
// - Brownout reset keeps threshold register
// - Brownout flag set, software clears
// - Threshold corrupt flag set, software clears
// - Brownout disabled in power down
// - Cause bits 7..3 read zero
// - Running watchdog timeout acts like pin
// - Sleep timeout clears pc, sp only
// - Watchdog control corrupt flag, software clears
// - Sleep timeout sets timeout, powerdown flags
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rss_sequencer #(
  parameter int RESET_DELAY_CYC = rss_pkg::RESET_DELAY_CYC,
  parameter int SOFT_DELAY_CYC  = rss_pkg::SOFT_DELAY_CYC,
  parameter int DEBOUNCE_CYC    = rss_pkg::DEBOUNCE_CYC
) (
  // Clock and power-on reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Reset sources
  input  wire logic       external_reset_pin_n,
  input  wire logic       supply_low,
  input  wire logic       wdt_overflow,
  input  wire logic       wdt_ctrl_corrupt,
  input  wire logic       sleep_mode,
  input  wire logic       powerdown_mode,
  // Register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Core controls
  output logic            core_reset,
  output logic            pc_sp_clear,
  output logic      [1:0] threshold_level,
  output logic            startup_timer_busy,
  output logic            irq
);

  // ----------------------------------------------------------------
  // Local signals
  // ----------------------------------------------------------------
  rss_pkg::rss_req_t    req;        // Bundled bus request
  rss_pkg::rss_state_t  state_r;    // Sequencer state
  rss_pkg::rss_state_t  state_nxt;  // Next state
  logic [7:0]  thresh_r;            // Threshold select register
  logic        thr_valid;           // Code is one of four
  logic [7:0]  thresh_nxt;          // Threshold register next value
  logic [1:0]  level_nxt;           // Decoded level of next value
  logic [31:0] deb_cnt_r;           // Low supply debounce counter
  logic        lvr_event;           // Debounced brownout
  logic        lvr_enable;          // Brownout monitor enabled
  logic [31:0] dly_cnt_r;           // Delay counter
  logic [31:0] dly_load;            // Delay load value
  logic        bad_pend_r;          // Invalid code pending reset
  logic [31:0] soft_cnt_r;          // Soft delay counter
  logic        soft_fire;           // Soft delay expired
  logic        wdt_run_evt;         // Running timeout
  logic        wdt_slp_evt;         // Sleep timeout
  logic [2:0]  cause_r;             // Cause flags
  logic [1:0]  wstat_r;             // Timeout / powerdown flags
  logic [5:0]  irq_st_r;            // Interrupt status
  logic [5:0]  irq_mk_r;            // Interrupt mask
  logic [5:0]  irq_ev;              // Interrupt events
  logic        wdt_bad_evt;         // Watchdog control corrupt event
  logic        ext_low;             // Pin asserted

  assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
  assign ext_low = !external_reset_pin_n;

  // ----------------------------------------------------------------
  // Threshold decode
  // ----------------------------------------------------------------
  // validity of held code
  // Any other byte means the register was disturbed
  always_comb
  begin
    thr_valid = 1'b0;
    case (thresh_r)
      rss_pkg::THR_2V10: thr_valid = 1'b1;
      rss_pkg::THR_2V55: thr_valid = 1'b1;
      rss_pkg::THR_3V15: thr_valid = 1'b1;
      rss_pkg::THR_3V80: thr_valid = 1'b1;
      default:           thr_valid = 1'b0;
    endcase
  end

  // Threshold next value; restore outranks a same-cycle write
  always_comb
  begin
    thresh_nxt = thresh_r;
    if (soft_fire)
      thresh_nxt = rss_pkg::THR_RESET;
    else if (req.wr && req.addr == rss_pkg::ADDR_THRESH)
      thresh_nxt = req.wdata;
  end

  // Threshold register; core reset does not touch it
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      thresh_r <= rss_pkg::THR_RESET;
    else
      thresh_r <= thresh_nxt;
  end

  // level of the value being stored
  // Decoding the next value lets the level leave a flip-flop in the
  // same cycle as the register itself; a bad code keeps level 0
  always_comb
  begin
    level_nxt = 2'd0;
    case (thresh_nxt)
      rss_pkg::THR_2V10: level_nxt = 2'd0;
      rss_pkg::THR_2V55: level_nxt = 2'd1;
      rss_pkg::THR_3V15: level_nxt = 2'd2;
      rss_pkg::THR_3V80: level_nxt = 2'd3;
      default:           level_nxt = 2'd0;
    endcase
  end

  // Registered level output for the comparator
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      threshold_level <= 2'd0;
    else
      threshold_level <= level_nxt;
  end

  // ----------------------------------------------------------------
  // Brownout debounce
  // ----------------------------------------------------------------
  // enabled unless powered down
  assign lvr_enable = !powerdown_mode;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      deb_cnt_r <= '0;
    else if (!supply_low || !lvr_enable)
      deb_cnt_r <= '0;
    else if (deb_cnt_r <= 32'(DEBOUNCE_CYC))
      deb_cnt_r <= deb_cnt_r + 32'd1;
  end
  // Fires once when the low state outlasts the debounce time
  assign lvr_event = lvr_enable && supply_low && (deb_cnt_r == 32'(DEBOUNCE_CYC));

  // ----------------------------------------------------------------
  // Invalid threshold soft reset delay
  // ----------------------------------------------------------------
  // count soft delay
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bad_pend_r <= 1'b0;
      soft_cnt_r <= '0;
    end
    else if (soft_fire)
    begin
      bad_pend_r <= 1'b0;
      soft_cnt_r <= '0;
    end
    else if (!thr_valid)
    begin
      bad_pend_r <= 1'b1;
      soft_cnt_r <= soft_cnt_r + 32'd1;
    end
    else
    begin
      // Rewritten to a valid code before expiry: abandon
      bad_pend_r <= 1'b0;
      soft_cnt_r <= '0;
    end
  end
  // Expiry counts only while the bad code is still held
  assign soft_fire = bad_pend_r && !thr_valid && (soft_cnt_r >= 32'(SOFT_DELAY_CYC));

  // ----------------------------------------------------------------
  // Watchdog event split
  // ----------------------------------------------------------------
  // running timeout
  assign wdt_run_evt = wdt_overflow && !sleep_mode;
  // sleep timeout, pc and sp only
  assign wdt_slp_evt = wdt_overflow && sleep_mode;
  assign pc_sp_clear = wdt_slp_evt;
  // Watchdog control corrupt pulse acts as a soft reset source
  assign wdt_bad_evt = wdt_ctrl_corrupt;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Next state; the pin outranks every internal source
  always_comb
  begin
    state_nxt = state_r;
    dly_load  = 32'(RESET_DELAY_CYC);
    case (state_r)
      rss_pkg::RSS_RUN:
      begin
        if (ext_low)
          state_nxt = rss_pkg::RSS_HOLD;
        else if (lvr_event || wdt_run_evt || soft_fire || wdt_bad_evt)
          state_nxt = rss_pkg::RSS_WAIT;
      end
      rss_pkg::RSS_HOLD:
      begin
        if (!ext_low)
          state_nxt = rss_pkg::RSS_WAIT;
      end
      rss_pkg::RSS_WAIT:
      begin
        if (ext_low)
          state_nxt = rss_pkg::RSS_HOLD;
        else if (dly_cnt_r <= 32'd1)
          state_nxt = rss_pkg::RSS_RUN;
      end
      default:
        state_nxt = rss_pkg::RSS_HOLD;
    endcase
    // Soft resets use the soft delay
    if (state_r == rss_pkg::RSS_RUN && (soft_fire || wdt_bad_evt))
      dly_load = 32'(SOFT_DELAY_CYC);
  end

  // State register; power-on starts with the startup delay
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      state_r <= rss_pkg::RSS_WAIT;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      dly_cnt_r <= 32'(RESET_DELAY_CYC);
    else if (state_r != rss_pkg::RSS_WAIT && state_nxt == rss_pkg::RSS_WAIT)
      dly_cnt_r <= dly_load;
    else if (state_r == rss_pkg::RSS_WAIT && dly_cnt_r != 32'd0)
      dly_cnt_r <= dly_cnt_r - 32'd1;
  end

  // Core reset while not running
  assign core_reset         = (state_r != rss_pkg::RSS_RUN);
  assign startup_timer_busy = (state_r == rss_pkg::RSS_WAIT);

  // ----------------------------------------------------------------
  // Cause flags: set wins over software clear
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      cause_r <= 3'b000;
    else
    begin
      if (req.wr && req.addr == rss_pkg::ADDR_CAUSE)
        cause_r <= req.wdata[2:0];
      if (lvr_event)
        cause_r[rss_pkg::BIT_BROWNOUT] <= 1'b1;
      if (!thr_valid)
        cause_r[rss_pkg::BIT_THR_BAD] <= 1'b1;
      if (wdt_bad_evt)
        cause_r[rss_pkg::BIT_WDT_BAD] <= 1'b1;
    end
  end

  // Timeout and powerdown flags; write zero clears
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      wstat_r <= 2'b00;
    else
    begin
      if (req.wr && req.addr == rss_pkg::ADDR_WDT_ST)
        wstat_r <= req.wdata[1:0];
      if (wdt_overflow)
        wstat_r[rss_pkg::BIT_TIMEOUT] <= 1'b1;
      if (wdt_slp_evt)
        wstat_r[rss_pkg::BIT_PDOWN] <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  // Event vector at the package's status positions; the top bit is spare
  always_comb
  begin
    irq_ev                   = '0;
    irq_ev[rss_pkg::IRQ_EXT] = ext_low;
    irq_ev[rss_pkg::IRQ_LVR] = lvr_event;
    irq_ev[rss_pkg::IRQ_THR] = soft_fire;
    irq_ev[rss_pkg::IRQ_WDT] = wdt_overflow;
    irq_ev[rss_pkg::IRQ_WCB] = wdt_bad_evt;
  end

  // Sticky status, write one clears, set wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_st_r <= '0;
    else if (req.wr && req.addr == rss_pkg::ADDR_IRQ_ST)
      irq_st_r <= (irq_st_r & ~req.wdata[5:0]) | irq_ev;
    else
      irq_st_r <= irq_st_r | irq_ev;
  end

  // Mask register, one enables
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      irq_mk_r <= '0;
    else if (req.wr && req.addr == rss_pkg::ADDR_IRQ_MK)
      irq_mk_r <= req.wdata[5:0];
  end

  // Level output, high while any unmasked status bit is set
  assign irq = |(irq_st_r & irq_mk_r);

  // ----------------------------------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (req.rd)
    begin
      case (req.addr)
        rss_pkg::ADDR_THRESH: reg_rdata <= thresh_r;
        rss_pkg::ADDR_CAUSE:  reg_rdata <= {5'b00000, cause_r};
        rss_pkg::ADDR_IRQ_ST: reg_rdata <= {2'b00, irq_st_r};
        rss_pkg::ADDR_IRQ_MK: reg_rdata <= {2'b00, irq_mk_r};
        rss_pkg::ADDR_WDT_ST: reg_rdata <= {6'b000000, wstat_r};
        default:              reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

endmodule
`default_nettype wire

// >>> hw/rss_pkg.sv
// Purpose: Shared constants and types for the reset source sequencer
// Assumes: 125 MHz core clock, 8-bit register port
// Notes:   Delay times are given in microseconds, cycle counts derived
package rss_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_THRESH = 4'h0; // Brownout threshold register
  localparam logic [3:0] ADDR_CAUSE  = 4'h1; // Reset cause register
  localparam logic [3:0] ADDR_IRQ_ST = 4'h2; // Interrupt status
  localparam logic [3:0] ADDR_IRQ_MK = 4'h3; // Interrupt mask
  localparam logic [3:0] ADDR_WDT_ST = 4'h4; // Watchdog / powerdown flags

  // ----------------------------------------------------------------
  // Threshold codes and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] THR_2V10  = 8'h55;
  localparam logic [7:0] THR_2V55  = 8'h33;
  localparam logic [7:0] THR_3V15  = 8'h99;
  localparam logic [7:0] THR_3V80  = 8'hAA;
  localparam logic [7:0] THR_RESET = 8'h55;

  // Cause register field positions
  localparam int BIT_BROWNOUT = 2;
  localparam int BIT_THR_BAD  = 1;
  localparam int BIT_WDT_BAD  = 0;
  // Watchdog status field positions
  localparam int BIT_TIMEOUT  = 1;
  localparam int BIT_PDOWN    = 0;
  // Interrupt status positions
  localparam int IRQ_EXT = 0;
  localparam int IRQ_LVR = 1;
  localparam int IRQ_THR = 2;
  localparam int IRQ_WDT = 3;
  localparam int IRQ_WCB = 4;
  localparam int IRQ_W   = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ          = 125;
  localparam int RESET_DELAY_US   = 50;  // reset_delay_time
  localparam int SOFT_DELAY_US    = 50;  // soft_reset_delay
  localparam int DEBOUNCE_US      = 10;  // brownout_debounce_time
  localparam int RESET_DELAY_CYC  = RESET_DELAY_US * CLK_MHZ;
  localparam int SOFT_DELAY_CYC   = SOFT_DELAY_US * CLK_MHZ;
  localparam int DEBOUNCE_CYC     = DEBOUNCE_US * CLK_MHZ;

  // Sequencer states
  typedef enum logic [1:0] {
    RSS_RUN  = 2'b00,
    RSS_HOLD = 2'b01,
    RSS_WAIT = 2'b10
  } rss_state_t;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } rss_req_t;

endpackage

// >>> bench/rss_checker.sv
// Purpose: Port assertions for the reset sequencer
// Assumes: One clock, short delay parameters
// Notes:   Bound into every sequencer instance
`timescale 1ns/1ps
`default_nettype none
module rss_checker #(
  parameter int DEBOUNCE_CYC = 8
) (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // Reset sources
  input wire logic       external_reset_pin_n,
  input wire logic       supply_low,
  input wire logic       wdt_overflow,
  input wire logic       sleep_mode,
  input wire logic       powerdown_mode,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Core side
  input wire logic       core_reset,
  input wire logic       pc_sp_clear
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Low-supply run length; powerdown masks the monitor
  logic [7:0] low_cnt_r;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n) low_cnt_r <= 8'h00;
    else if (!supply_low || powerdown_mode) low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hFF) low_cnt_r <= low_cnt_r + 8'h01;
  property p_pin_hold; !external_reset_pin_n |=> core_reset; endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("core ran with pin low");
  property p_delay; $rose(external_reset_pin_n) |-> core_reset [*8]; endproperty
  a_delay: assert property (p_delay) else $error("startup delay cut short");
  property p_release; $rose(external_reset_pin_n) |-> ##[8:24] !core_reset; endproperty
  a_release: assert property (p_release) else $error("core never released");
  property p_lvr; low_cnt_r == DEBOUNCE_CYC + 1 |-> ##[0:4] core_reset; endproperty
  a_lvr: assert property (p_lvr) else $error("long dip gave no reset");
  property p_pdown;
    powerdown_mode && supply_low && external_reset_pin_n && !core_reset && !wdt_overflow
      && !reg_wr |=> !core_reset;
  endproperty
  a_pdown: assert property (p_pdown) else $error("dip reset in powerdown");
  property p_wdt_run; wdt_overflow && !sleep_mode |-> ##[1:2] core_reset; endproperty
  a_wdt_run: assert property (p_wdt_run) else $error("timeout gave no reset");
  property p_wdt_sleep;
    wdt_overflow && sleep_mode && !core_reset && external_reset_pin_n |=> !core_reset;
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep) else $error("sleep timeout fully reset");
  property p_pcsp; pc_sp_clear == (wdt_overflow && sleep_mode); endproperty
  a_pcsp: assert property (p_pcsp) else $error("pc sp clear wrong");
  property p_cause_hi;
    reg_rd && reg_addr == rss_pkg::ADDR_CAUSE |=> reg_rdata[7:3] == 5'h00;
  endproperty
  a_cause_hi: assert property (p_cause_hi) else $error("cause upper bits set");
  c_release: cover property ($fell(core_reset));
  c_sleep: cover property (pc_sp_clear);
  c_dip: cover property (low_cnt_r == DEBOUNCE_CYC + 1);
endmodule
bind rss_sequencer rss_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) rss_checker_inst (
  .clock, .rst_n, .external_reset_pin_n, .supply_low, .wdt_overflow, .sleep_mode,
  .powerdown_mode, .reg_addr, .reg_wr, .reg_rd, .reg_rdata, .core_reset, .pc_sp_clear);
`default_nettype wire

// >>> bench/rss_supply_model.sv
// Purpose: External reset network and supply monitor
// Assumes: Driven from bench tasks
// Notes:   Pin rests high through its pull-up
`timescale 1ns/1ps
`default_nettype none
module rss_supply_model (
  // Clock
  input  wire logic clock,
  // Driven lines
  output var logic  external_reset_pin_n,
  output var logic  supply_low
);
  initial external_reset_pin_n = 1'b1;
  initial supply_low = 1'b0;
  // Pull pin low n cycles, then the pull-up lets it rise
  task automatic press(input int n);
    @(posedge clock) external_reset_pin_n <= 1'b0;
    repeat (n) @(posedge clock);
    external_reset_pin_n <= 1'b1;
  endtask
  // Comparator reports low supply for n sampled cycles
  task automatic dip(input int n);
    @(posedge clock) supply_low <= 1'b1;
    repeat (n) @(posedge clock);
    supply_low <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> bench/reset_source_sequencer_tb.sv
// Purpose: Self-checking bench for the reset sequencer
// Assumes: Delays shortened to 8 cycles
// Notes:   Flag model kept in ints
`timescale 1ns/1ps
`default_nettype none
module reset_source_sequencer_tb;
  localparam int D = 8; // Shortened delay counts
  logic clock, rst_n, wdt_overflow, wdt_ctrl_corrupt, sleep_mode, powerdown_mode;
  logic reg_wr, reg_rd, external_reset_pin_n, supply_low, core_reset, pc_sp_clear;
  logic startup_timer_busy, irq, a;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [1:0] threshold_level;
  logic [15:0] lf = 16'h23FB; // Seed 9211
  int n_errors, n_compared, cyc, thr, cause, wflg;
  int codes[$] = '{8'h55, 8'h33, 8'h99, 8'hAA}; // Valid thresholds in level order
  rss_sequencer #(.RESET_DELAY_CYC(D), .SOFT_DELAY_CYC(D), .DEBOUNCE_CYC(D))
    rss_sequencer_inst (.clock, .rst_n, .external_reset_pin_n, .supply_low,
    .wdt_overflow, .wdt_ctrl_corrupt, .sleep_mode, .powerdown_mode, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .core_reset, .pc_sp_clear,
    .threshold_level, .startup_timer_busy, .irq);
  rss_supply_model rss_supply_model_inst (.clock, .external_reset_pin_n, .supply_low);
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  function automatic logic [15:0] nxt(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] ad, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1; reg_addr <= ad; reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] ad, input int e);
    @(posedge clock);
    reg_rd <= 1'b1; reg_addr <= ad;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e[7:0]);
  endtask
  // Bounded wait for core reset to reach a level
  task automatic wait_for(input logic lvl);
    repeat (60) if (core_reset !== lvl) @(negedge clock);
    chk("core_reset", {7'h00, core_reset}, {7'h00, lvl});
  endtask
  task automatic pulse_wdt;
    @(posedge clock) wdt_overflow <= 1'b1;
    @(negedge clock) chk("pc_sp", {7'h00, pc_sp_clear}, {7'h00, sleep_mode});
    @(posedge clock) wdt_overflow <= 1'b0;
  endtask
  task automatic give_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_errors++;
      give_verdict;
    end
  end
  initial
  begin
    int v;
    {reg_wr, reg_rd, wdt_overflow, wdt_ctrl_corrupt, sleep_mode, powerdown_mode} = '0;
    reg_addr = 4'h0; reg_wdata = 8'h00; rst_n = 1'b0; thr = 8'h55;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    wait_for(1'b0);
    rd(rss_pkg::ADDR_THRESH, thr);
    rd(rss_pkg::ADDR_CAUSE, cause);
    foreach (codes[i])
    begin
      wr(rss_pkg::ADDR_THRESH, codes[i][7:0]);
      #1 chk("level", {6'h00, threshold_level}, i[7:0]);
      thr = codes[i];
    end
    rss_supply_model_inst.press(5);
    #1 chk("busy", {7'h00, startup_timer_busy}, 8'h00);
    wait_for(1'b0);
    rd(rss_pkg::ADDR_CAUSE, cause);
    lf = nxt(lf);
    rss_supply_model_inst.dip(1 + lf[2:0]);
    repeat (4) @(negedge clock);
    chk("core_reset", {7'h00, core_reset}, 8'h00);
    rss_supply_model_inst.dip(D + 3);
    wait_for(1'b1);
    chk("busy", {7'h00, startup_timer_busy}, 8'h01);
    wait_for(1'b0);
    cause = cause | 4;
    rd(rss_pkg::ADDR_THRESH, thr);
    rd(rss_pkg::ADDR_CAUSE, cause);
    wr(rss_pkg::ADDR_IRQ_MK, 8'h00);
    #1 a = irq;
    wr(rss_pkg::ADDR_IRQ_MK, 8'hFF);
    #1 chk("irq_mask", {7'h00, irq ^ a}, 8'h01);
    wr(rss_pkg::ADDR_IRQ_ST, 8'hFF);
    #1 chk("irq_clear", {7'h00, irq}, 8'h00);
    wr(rss_pkg::ADDR_CAUSE, 8'h00);
    cause = 0;
    rd(rss_pkg::ADDR_CAUSE, cause);
    @(posedge clock) powerdown_mode <= 1'b1;
    rss_supply_model_inst.dip(D + 3);
    repeat (4) @(negedge clock);
    chk("core_reset", {7'h00, core_reset}, 8'h00);
    @(posedge clock) powerdown_mode <= 1'b0;
    lf = nxt(lf);
    v = lf[7:0];
    foreach (codes[i]) if (v == codes[i]) v = v ^ 1;
    wr(rss_pkg::ADDR_THRESH, v[7:0]);
    wait_for(1'b1);
    wait_for(1'b0);
    thr = 8'h55;
    cause = cause | 2;
    rd(rss_pkg::ADDR_THRESH, thr);
    rd(rss_pkg::ADDR_CAUSE, cause);
    pulse_wdt;
    wait_for(1'b1);
    wait_for(1'b0);
    wflg = 2;
    rd(rss_pkg::ADDR_WDT_ST, wflg);
    @(posedge clock) sleep_mode <= 1'b1;
    pulse_wdt;
    repeat (4) @(negedge clock);
    chk("core_reset", {7'h00, core_reset}, 8'h00);
    wflg = 3;
    rd(rss_pkg::ADDR_WDT_ST, wflg);
    @(posedge clock) sleep_mode <= 1'b0;
    @(posedge clock) wdt_ctrl_corrupt <= 1'b1;
    @(posedge clock) wdt_ctrl_corrupt <= 1'b0;
    repeat (40) @(negedge clock);
    wait_for(1'b0);
    cause = cause | 1;
    rd(rss_pkg::ADDR_CAUSE, cause);
    wr(4'hF, 8'hFF);
    rd(4'hF, 0);
    give_verdict;
  end
endmodule
`default_nettype wire
